// ==== design/csp_fifo.sv ====
// csp_fifo: synchronous word FIFO with valid/ready on both sides.
// assumes depth is a power of two; clear_in empties it on the next edge.
`timescale 1ns/1ps
`default_nettype none

module csp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clear_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];
    assign push = in_valid_in && !full;
    assign pop = out_ready_in && !empty;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (clear_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== design/csp_pkg.sv ====
// csp_pkg: constants, carriers and states shared by the serial port block.
// assumes one clock domain (master clock) and pins synchronised in the block.
`default_nettype none

package csp_pkg;

    // ********************************************************************
    // frame geometry and widths
    // ********************************************************************
    localparam int WORD_W = 16;
    localparam int SLOT_BITS = 16;
    localparam int DEV_W = 4;
    localparam int DIV_W = 8;
    localparam int POS_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] BIT_LAST = 4'hf;
    localparam logic [POS_W-1:0] POS_IDLE = 8'hff;
    localparam logic [POS_W-1:0] POS_SLOT_END = 8'h10;

    // ********************************************************************
    // pin vector positions and synchroniser reset value
    // ********************************************************************
    localparam int PIN_W = 6;
    localparam int PIN_MS = 0;
    localparam int PIN_SLEEP = 1;
    localparam int PIN_RST = 2;
    localparam int PIN_SCLK = 3;
    localparam int PIN_FS = 4;
    localparam int PIN_DIN = 5;
    localparam logic [PIN_W-1:0] PIN_SYNC_RST = 6'h00;

    // ********************************************************************
    // configuration defaults after reset
    // ********************************************************************
    localparam logic [DEV_W-1:0] DEV_M1_RST = 4'h0;
    localparam logic [DIV_W-1:0] HALF_DIV_RST = 8'h04;

    // cascade size minus one, and master clocks per shift-clock half
    typedef struct packed {
        logic [DEV_W-1:0] dev_m1;
        logic [DIV_W-1:0] half_div;
    } csp_cfg_t;

    // output side of a two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } csp_pin_t;

    typedef enum logic [0:0] {
        CSP_IDLE,
        CSP_FRAME
    } csp_state_t;

endpackage

`default_nettype wire

// ==== design/csp_serial_port.sv ====
// csp_serial_port: codec serial data port, pin side.
// master role makes shift clock and frame sync from the master clock;
// slave role follows both from the processor. all logic on clk_in.
// assumes clk_in is the master clock and pins are asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - master/slave pin high selects master role
// - sleep_n low disables port, stops clocks
// - configuration kept; resume after sleep_n high
// - sleep clears counters only, not configuration
// - hardware reset loads defaults everywhere
// - master shift clock is fs times 16 times cascade
// - data shifted only inside frame-sync interval
// - all internal clocks derived from master clock
// - sample data input on falling shift edge
// - launch on rising edge; output off outside frame
// - transfer starts at fs fall, 16 clocks
// - master drives fs low in slot; slave follows
module csp_serial_port #(
    parameter int FIFO_DEPTH = csp_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic master_sel_in,
    input wire logic sleep_n_in,
    input wire logic hw_reset_n_in,
    input wire logic sclk_in,
    output csp_pkg::csp_pin_t sclk_out,
    input wire logic frame_sync_in,
    output csp_pkg::csp_pin_t frame_sync_out,
    input wire logic sdin_in,
    output csp_pkg::csp_pin_t sdout_out,
    input wire csp_pkg::csp_cfg_t cfg_in,
    input wire logic cfg_load_in,
    output csp_pkg::csp_cfg_t cfg_out,
    input wire logic [csp_pkg::WORD_W-1:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [csp_pkg::WORD_W-1:0] rx_data_out,
    output logic rx_valid_out,
    output logic awake_out
);
    import csp_pkg::*;

    // ********************************************************************
    // declarations
    // ********************************************************************
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic hw_rst;
    logic awake;
    logic master;
    logic run_master;
    csp_cfg_t cfg_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic sclk_r;
    logic fs_r;
    logic [POS_W-1:0] pos_r;
    logic [POS_W-1:0] pos_last;
    logic [POS_W-1:0] pos_nxt;
    logic tick;
    logic m_rise;
    logic m_fall;
    logic sclk_d_r;
    logic s_rise;
    logic s_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic fs_low_rise;
    logic fs_low_fall;
    csp_state_t state_r;
    logic [3:0] tx_cnt_r;
    logic [3:0] rx_cnt_r;
    logic [WORD_W-1:0] tx_sh_r;
    logic [WORD_W-1:0] rx_sh_r;
    logic sdout_r;
    logic sdout_oe_r;
    logic start;
    logic [WORD_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [WORD_W-1:0] load_word;

    // true while slot position lies in this device's 16-bit window
    function automatic logic in_slot(input logic [POS_W-1:0] pos);
        in_slot = (pos < POS_SLOT_END);
    endfunction

    // ********************************************************************
    // pin synchronisers
    // ********************************************************************
    assign pins = {sdin_in, frame_sync_in, sclk_in, hw_reset_n_in,
                   sleep_n_in, master_sel_in};

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_r <= PIN_SYNC_RST;
            sync2_r <= PIN_SYNC_RST;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    assign hw_rst = !sync2_r[PIN_RST];
    assign awake = sync2_r[PIN_SLEEP] && !hw_rst;
    assign master = sync2_r[PIN_MS];
    assign run_master = master && awake;
    assign awake_out = awake;

    // ********************************************************************
    // configuration: survives sleep, defaulted by hardware reset
    // ********************************************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_r.dev_m1 <= DEV_M1_RST;
            cfg_r.half_div <= HALF_DIV_RST;
        end else if (hw_rst) begin
            cfg_r.dev_m1 <= DEV_M1_RST;
            cfg_r.half_div <= HALF_DIV_RST;
        end else if (cfg_load_in) begin
            cfg_r <= cfg_in;
        end
    end

    assign cfg_out = cfg_r;

    // ********************************************************************
    // master role: shift clock and frame sync generator
    // ********************************************************************
    // frame is 16 bits per cascaded codec, so last slot index is
    // {devices-1, 1111}
    assign pos_last = {cfg_r.dev_m1, BIT_LAST};
    assign pos_nxt = (pos_r >= pos_last) ? '0 : pos_r + 1'b1;
    // half_div of zero behaves as one, never a stuck clock
    assign tick = (div_cnt_r + 1'b1 >= cfg_r.half_div);
    assign m_rise = tick && !sclk_r;
    assign m_fall = tick && sclk_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_cnt_r <= '0;
            sclk_r <= 1'b0;
        end else if (hw_rst || !run_master) begin
            div_cnt_r <= '0;
            sclk_r <= 1'b0;
        end else if (tick) begin
            div_cnt_r <= '0;
            sclk_r <= !sclk_r;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    // frame sync moves on the rising edge so the processor sees it
    // settled at the following falling edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pos_r <= POS_IDLE;
            fs_r <= 1'b1;
        end else if (hw_rst || !run_master) begin
            pos_r <= POS_IDLE;
            fs_r <= 1'b1;
        end else if (m_rise) begin
            pos_r <= pos_nxt;
            fs_r <= !in_slot(pos_nxt);
        end
    end

    // ********************************************************************
    // slave role: edges of the external shift clock
    // ********************************************************************
    // the external clock must be locked to clk_in and slow enough for
    // the synchronised copy to show each level for a cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sync2_r[PIN_SCLK];
        end
    end

    assign s_rise = sync2_r[PIN_SCLK] && !sclk_d_r;
    assign s_fall = !sync2_r[PIN_SCLK] && sclk_d_r;

    // ********************************************************************
    // shared edge and frame selection
    // ********************************************************************
    assign sclk_rise = awake && (master ? m_rise : s_rise);
    assign sclk_fall = awake && (master ? m_fall : s_fall);
    assign fs_low_rise = master ? in_slot(pos_nxt) : !sync2_r[PIN_FS];
    assign fs_low_fall = master ? !fs_r : !sync2_r[PIN_FS];

    // ********************************************************************
    // transmit word source
    // ********************************************************************
    // a frame starts at the first rising edge seen with frame sync low;
    // back to back frames follow when sync stays low past bit 15
    assign start = sclk_rise && fs_low_rise &&
                   (state_r == CSP_IDLE || tx_cnt_r == BIT_LAST);
    assign fifo_pop = start && fifo_valid;
    // an empty buffer sends a zero word rather than stalling the frame
    assign load_word = fifo_valid ? fifo_data : '0;

    csp_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(hw_rst),
        .in_data_in(tx_data_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop)
    );

    // ********************************************************************
    // frame state and transmit shifter
    // ********************************************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= CSP_IDLE;
            tx_cnt_r <= '0;
        end else if (hw_rst || !awake) begin
            state_r <= CSP_IDLE;
            tx_cnt_r <= '0;
        end else if (start) begin
            state_r <= CSP_FRAME;
            tx_cnt_r <= '0;
        end else if (!fs_low_fall) begin
            // a slave frame cut short by sync must not block the next one
            state_r <= CSP_IDLE;
            tx_cnt_r <= '0;
        end else if (sclk_rise && state_r == CSP_FRAME) begin
            if (tx_cnt_r == BIT_LAST) begin
                state_r <= CSP_IDLE;
                tx_cnt_r <= '0;
            end else begin
                tx_cnt_r <= tx_cnt_r + 1'b1;
            end
        end
    end

    // shift contents are data, not counters, so sleep leaves them
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_sh_r <= '0;
            sdout_r <= 1'b0;
        end else if (hw_rst) begin
            tx_sh_r <= '0;
            sdout_r <= 1'b0;
        end else if (start) begin
            tx_sh_r <= {load_word[WORD_W-2:0], 1'b0};
            sdout_r <= load_word[WORD_W-1];
        end else if (sclk_rise && state_r == CSP_FRAME &&
                     tx_cnt_r != BIT_LAST) begin
            tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
            sdout_r <= tx_sh_r[WORD_W-1];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sdout_oe_r <= 1'b0;
        end else if (hw_rst || !awake) begin
            sdout_oe_r <= 1'b0;
        end else if (start) begin
            sdout_oe_r <= 1'b1;
        end else if (!fs_low_fall) begin
            // slave clock may stop after bit 0, so sync high ends the drive
            sdout_oe_r <= 1'b0;
        end else if (sclk_rise && tx_cnt_r == BIT_LAST) begin
            sdout_oe_r <= 1'b0;
        end
    end

    // ********************************************************************
    // receive shifter
    // ********************************************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_cnt_r <= '0;
        end else if (hw_rst || !awake || start) begin
            rx_cnt_r <= '0;
        end else if (sclk_fall && state_r == CSP_FRAME && fs_low_fall) begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_sh_r <= '0;
        end else if (hw_rst) begin
            rx_sh_r <= '0;
        end else if (sclk_fall && state_r == CSP_FRAME && fs_low_fall) begin
            rx_sh_r <= {rx_sh_r[WORD_W-2:0], sync2_r[PIN_DIN]};
        end
    end

    // word handed out on the falling edge that takes its last bit
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_data_out <= '0;
            rx_valid_out <= 1'b0;
        end else if (hw_rst) begin
            rx_data_out <= '0;
            rx_valid_out <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (sclk_fall && state_r == CSP_FRAME && fs_low_fall &&
                rx_cnt_r == BIT_LAST) begin
                rx_data_out <= {rx_sh_r[WORD_W-2:0], sync2_r[PIN_DIN]};
                rx_valid_out <= 1'b1;
            end
        end
    end

    // ********************************************************************
    // pin drivers
    // ********************************************************************
    assign sclk_out = '{o: sclk_r, oe: run_master};
    assign frame_sync_out = '{o: fs_r, oe: run_master};
    assign sdout_out = '{o: sdout_r, oe: sdout_oe_r};

endmodule

`default_nettype wire

// ==== verification/csp_dsp_model.sv ====
// csp_dsp_model: processor serial port facing the codec.
// assumes pins resolved by the bench; run_in makes it link master.
`timescale 1ns/1ps
`default_nettype none
module csp_dsp_model #(
    parameter int HALF = 6
) (
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic [15:0] tx_word_in,
    input wire logic sclk_pin_in,
    input wire logic fs_pin_in,
    input wire csp_pkg::csp_pin_t dout_in,
    output logic sclk_out,
    output logic fs_out,
    output logic sdin_out,
    output logic [15:0] rx_word_out,
    output logic rx_done_out
);
    import csp_pkg::*;
    logic sclk_q = 1'b0;
    logic [3:0] tx_bit = 4'hf;
    logic [3:0] rx_bit = 4'h0;
    logic [15:0] rx_sh = 16'h0000;
    initial begin
        sclk_out = 1'b0;
        fs_out = 1'b1;
        sdin_out = 1'b0;
        rx_done_out = 1'b0;
    end
    // ********
    // frame maker; clock stands low between frames
    // ********
    always begin
        @(posedge clk_in);
        if (run_in) begin
            fs_out <= 1'b0;
            repeat (HALF) @(posedge clk_in);
            repeat (16) begin
                sclk_out <= 1'b1;
                repeat (HALF) @(posedge clk_in);
                sclk_out <= 1'b0;
                repeat (HALF) @(posedge clk_in);
            end
            fs_out <= 1'b1;
            repeat (4 * HALF) @(posedge clk_in);
        end
    end
    // ********
    // shifters driven by the resolved pins
    // ********
    always @(posedge clk_in) begin
        sclk_q <= sclk_pin_in;
        rx_done_out <= 1'b0;
        if (fs_pin_in) begin
            tx_bit <= 4'hf;
            rx_bit <= 4'h0;
            // toggling idle data so a stale bit never passes
            sdin_out <= ~sdin_out;
        end else if (sclk_pin_in && !sclk_q) begin
            sdin_out <= tx_word_in[tx_bit];
            tx_bit <= tx_bit - 4'h1;
        end else if (!sclk_pin_in && sclk_q) begin
            rx_sh <= {rx_sh[14:0], dout_in.oe ? dout_in.o : ~rx_sh[0]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'hf) begin
                rx_word_out <= {rx_sh[14:0], dout_in.oe ? dout_in.o : ~rx_sh[0]};
                rx_done_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/csp_serial_port_bench.sv ====
// csp_serial_port_bench: self-checking bench for the codec serial port.
// assumes csp_dsp_model on the link and the bound assertion checker.
`timescale 1ns/1ps
`default_nettype none
module csp_serial_port_bench;
    import csp_pkg::*;
    localparam logic [15:0] DSP_WORD = 16'ha5c3;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic master_sel = 1'b1;
    logic sleep_n = 1'b0;
    logic hw_reset_n = 1'b1;
    logic cfg_load = 1'b0;
    logic tx_valid = 1'b0;
    logic m_run = 1'b0;
    logic [15:0] tx_data = 16'h0000;
    csp_cfg_t cfg_v = 12'h004;
    csp_cfg_t cfg_q;
    csp_pin_t sclk_o, fs_o, dout_o;
    logic tx_ready, rx_valid, awake, m_sclk, m_fs, m_sdin, m_done;
    logic [15:0] rx_data, m_word;
    int n_errors = 0;
    int compares = 0;
    wire logic sclk_pin = sclk_o.oe ? sclk_o.o : m_sclk;
    wire logic fs_pin = fs_o.oe ? fs_o.o : m_fs;
    always #5 clk = ~clk;
    csp_serial_port uut (.clk_in(clk), .rst_b_in(rst_b),
        .master_sel_in(master_sel), .sleep_n_in(sleep_n),
        .hw_reset_n_in(hw_reset_n), .sclk_in(sclk_pin), .sclk_out(sclk_o),
        .frame_sync_in(fs_pin), .frame_sync_out(fs_o), .sdin_in(m_sdin),
        .sdout_out(dout_o), .cfg_in(cfg_v), .cfg_load_in(cfg_load),
        .cfg_out(cfg_q), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .awake_out(awake));
    csp_dsp_model u_dsp (.clk_in(clk), .run_in(m_run),
        .tx_word_in(DSP_WORD), .sclk_pin_in(sclk_pin), .fs_pin_in(fs_pin),
        .dout_in(dout_o), .sclk_out(m_sclk), .fs_out(m_fs),
        .sdin_out(m_sdin), .rx_word_out(m_word), .rx_done_out(m_done));
    // ********
    // compare and measure helpers
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_num(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_errors++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic get_word(input bit from_dsp, input logic [15:0] exp);
        int k;
        for (k = 0; k < 3000; k++) begin
            @(posedge clk);
            #1;
            if ((from_dsp ? m_done : rx_valid) === 1'b1) begin
                break;
            end
        end
        chk_num(int'(k < 3000), 1);
        chk(from_dsp ? m_word : rx_data, exp);
    endtask
    // cycles between two rises of shift clock, or two falls of frame sync
    task automatic period(input bit fs_sel, output int n);
        int t0;
        logic p;
        logic s;
        t0 = -1;
        n = -1;
        p = 1'b1;
        for (int c = 0; c < 5000 && n < 0; c++) begin
            @(posedge clk);
            #1;
            s = fs_sel ? ~fs_pin : sclk_pin;
            if (s && !p) begin
                if (t0 < 0) begin
                    t0 = c;
                end else begin
                    n = c - t0;
                end
            end
            p = s;
        end
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_defaults;
        chk({4'h0, cfg_q}, {4'h0, DEV_M1_RST, HALF_DIV_RST});
        chk({15'h0000, tx_ready}, 16'h0001);
        chk({15'h0000, awake}, 16'h0000);
    endtask
    task automatic t_fill;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            tx_data <= 16'hc000 + 16'(i);
            tx_valid <= 1'b1;
            @(posedge clk);
        end
        tx_valid <= 1'b0;
        #1;
        chk({15'h0000, tx_ready}, 16'h0000);
    endtask
    task automatic t_stream;
        int n;
        sleep_n <= 1'b1;
        fork
            get_word(1'b0, DSP_WORD);
            for (int i = 0; i < 9; i++) begin
                get_word(1'b1, i < 8 ? 16'hc000 + 16'(i) : 16'h0000);
            end
        join
        period(1'b0, n);
        chk_num(n, 8);
    endtask
    task automatic t_cascade;
        int n;
        sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({15'h0000, awake}, 16'h0000);
        cfg_v <= 12'h103;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        sleep_n <= 1'b1;
        period(1'b0, n);
        chk_num(n, 6);
        period(1'b1, n);
        chk_num(n, 192);
        sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        sleep_n <= 1'b1;
        period(1'b0, n);
        chk_num(n, 6);
        chk({4'h0, cfg_q}, 16'h0103);
    endtask
    task automatic t_hw_reset;
        sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        tx_data <= 16'h7e81;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({4'h0, cfg_q}, {4'h0, DEV_M1_RST, HALF_DIV_RST});
        sleep_n <= 1'b1;
        get_word(1'b1, 16'h0000);
    endtask
    task automatic t_slave;
        sleep_n <= 1'b0;
        master_sel <= 1'b0;
        repeat (4) @(posedge clk);
        tx_data <= 16'h3cf0;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        sleep_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({15'h0000, sclk_o.oe}, 16'h0000);
        m_run <= 1'b1;
        fork
            get_word(1'b0, DSP_WORD);
            get_word(1'b1, 16'h3cf0);
        join
        repeat (8) @(posedge clk);
        #1;
        chk({15'h0000, dout_o.oe}, 16'h0000);
        m_run <= 1'b0;
    endtask
    initial begin
        #300000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // synchronised reset pin keeps the buffer clear for two edges
        repeat (3) @(posedge clk);
        #1;
        t_defaults();
        t_fill();
        t_stream();
        t_cascade();
        t_hw_reset();
        t_slave();
        finish_test();
    end
endmodule
`default_nettype wire

// ==== verification/csp_serial_port_sva.sv ====
// csp_serial_port_sva: pin-level assertions for the serial port.
// assumes binding into csp_serial_port, one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module csp_serial_port_sva (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic master_sel_in,
    input wire logic hw_reset_n_in,
    input wire logic frame_sync_in,
    input wire csp_pkg::csp_pin_t sclk_out,
    input wire csp_pkg::csp_pin_t frame_sync_out,
    input wire csp_pkg::csp_pin_t sdout_out,
    input wire csp_pkg::csp_cfg_t cfg_in,
    input wire logic cfg_load_in,
    input wire csp_pkg::csp_cfg_t cfg_out,
    input wire logic rx_valid_out,
    input wire logic awake_out
);
    import csp_pkg::*;
    // ********
    // shift clock rises seen in the current frame
    // ********
    logic [5:0] rise_cnt_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rise_cnt_r <= 6'h00;
        end else if (frame_sync_out.o) begin
            rise_cnt_r <= 6'h00;
        end else if ($rose(sclk_out.o)) begin
            rise_cnt_r <= rise_cnt_r + 6'h01;
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_high_half;
        sclk_out.o[*4] ##1 !sclk_out.o;
    endsequence
    // pins pass a two-flop synchroniser, hence the three-cycle history
    a_slave_pins_off: assert property (
        (!master_sel_in)[*3] |-> !sclk_out.oe && !frame_sync_out.oe)
        else $error("link clock driven in slave role");
    a_master_pins_on: assert property (
        master_sel_in[*3] ##0 awake_out |-> sclk_out.oe && frame_sync_out.oe)
        else $error("link clock not driven in master role");
    a_sleep_quiet: assert property (
        (!awake_out)[*2] |-> !sclk_out.oe && !sdout_out.oe)
        else $error("pins driven while asleep");
    a_cfg_keep: assert property (
        (hw_reset_n_in && !cfg_load_in)[*4] |=> $stable(cfg_out))
        else $error("configuration changed without load");
    a_cfg_load: assert property (
        hw_reset_n_in[*4] ##0 cfg_load_in |=> cfg_out == $past(cfg_in))
        else $error("configuration load lost");
    a_hw_dflt: assert property (
        (!hw_reset_n_in)[*5] |-> cfg_out == {DEV_M1_RST, HALF_DIV_RST})
        else $error("hardware reset left configuration");
    a_sclk_half: assert property (disable iff (!rst_b_in || !awake_out)
        $rose(sclk_out.o) && cfg_out.half_div == 8'h04 |-> s_high_half)
        else $error("shift clock half period wrong");
    a_frame_sixteen: assert property (
        disable iff (!rst_b_in || !awake_out)
        $rose(frame_sync_out.o) && sclk_out.oe |-> rise_cnt_r == 6'h10)
        else $error("frame not sixteen shift clocks");
    a_dout_in_frame: assert property (
        sclk_out.oe && sdout_out.oe |-> !frame_sync_out.o)
        else $error("data out driven outside frame");
    a_dout_fs_high: assert property (
        frame_sync_in[*4] |-> !sdout_out.oe)
        else $error("data out driven with frame sync high");
    a_rx_spaced: assert property (
        rx_valid_out |=> (!rx_valid_out)[*8])
        else $error("received words too close");
endmodule
bind csp_serial_port csp_serial_port_sva u_sva (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .master_sel_in(master_sel_in),
    .hw_reset_n_in(hw_reset_n_in),
    .frame_sync_in(frame_sync_in),
    .sclk_out(sclk_out),
    .frame_sync_out(frame_sync_out),
    .sdout_out(sdout_out),
    .cfg_in(cfg_in),
    .cfg_load_in(cfg_load_in),
    .cfg_out(cfg_out),
    .rx_valid_out(rx_valid_out),
    .awake_out(awake_out)
);
`default_nettype wire
